// File: verilog/iac_top.sv
// Purpose: Maskable interrupt acceptance and entry sequence control.
// Assumes: APB slave on pclk; CPU gives instruction boundaries, PC, SP.
// Notes: Source 0 has the highest fixed priority among equal levels.
//
// The register addresses and the APB register port were chosen for this implementation.
`default_nettype none
`include "iac_cfg.svh"

module iac_top
    import iac_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`IAC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`IAC_FIRST_EDGE-1:0] src_req,
    input wire logic [`IAC_NEDGE-1:0] ext_pin,
    input wire logic instr_done,
    input wire logic string_op_active,
    input wire logic [19:0] cpu_pc,
    input wire logic [15:0] cpu_sp,
    input wire logic vector_odd,
    input wire logic bus_8bit,
    input wire logic special_req,
    input wire iac_kind_t special_kind,
    input wire logic [5:0] special_num,
    output iac_info_t info,
    output iac_push_t push,
    output logic [15:0] flag_word,
    output logic seq_busy,
    output logic seq_done,
    output logic suspend
);

    function automatic logic [`IAC_IDX_W:0] pick_best(
        input logic [`IAC_NSRC-1:0] ok,
        input iac_ctrl_t c [`IAC_NSRC]
    );
        logic found;
        logic [`IAC_IDX_W-1:0] idx;
        logic [`IAC_LVL_W-1:0] best;
        found = 1'b0;
        idx = '0;
        best = `IAC_LVL_OFF;
        // Scanning downward with >= lets the lower index win a tie.
        for (int i = `IAC_NSRC - 1; i >= 0; i--)
        begin
            if (ok[i] && (!found || c[i].lvl >= best))
            begin
                found = 1'b1;
                idx = i[`IAC_IDX_W-1:0];
                best = c[i].lvl;
            end
        end
        return {found, idx};
    endfunction

    function automatic logic [4:0] seq_len(
        input logic b8,
        input logic vodd,
        input logic spodd,
        input iac_kind_t k,
        input logic masked
    );
        logic [4:0] n;
        n = b8 ? `IAC_SEQ_BUS8 :
            5'(`IAC_SEQ_BASE + {4'h0, vodd} + {4'h0, spodd});
        if (!masked && k == IAC_K_DBC)
            n = 5'(n + `IAC_EXTRA_DBC);
        else if (!masked && (k == IAC_K_SSTEP || k == IAC_K_ADDR))
            n = 5'(n + `IAC_EXTRA_ONE);
        return n;
    endfunction

    iac_ctrl_t ctrl_q [`IAC_NSRC];
    iac_ctrl_t ctrl_d [`IAC_NSRC];
    logic [`IAC_NEDGE-1:0] sync1_q, sync2_q, sync3_q;
    logic [`IAC_NEDGE-1:0] filt_q, filt_d;
    logic [15:0] flag_q, flag_d, tmp_q;
    iac_state_t st_q, st_d;
    logic [4:0] cnt_q, len_q, wait_q;
    logic [1:0] pidx_q;
    logic masked_q, sp_odd_q, late_q, sp_pend_q;
    logic [`IAC_IDX_W-1:0] src_q;
    logic [`IAC_LVL_W-1:0] lvl_q;
    iac_kind_t kind_q, sp_kind_q;
    logic [5:0] num_q, sp_num_q;
    logic [19:0] pc_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, done_q, susp_q, busy_q;
    iac_info_t info_q;
    iac_push_t push_q;

    // Register bus decode.
    wire apb_acc = psel && penable && !pready_q;
    wire apb_fin = psel && penable && pready_q;
    wire aligned = paddr[1:0] == 2'b00;
    wire hit_ctrl = aligned && paddr < `IAC_CTRL_SPAN;
    wire hit_flag = aligned && paddr == `IAC_OFF_FLAG;
    wire hit_stat = aligned && paddr == `IAC_OFF_STAT;
    wire hit_any = hit_ctrl || hit_flag || hit_stat;
    wire [`IAC_IDX_W-1:0] widx = paddr[`IAC_IDX_W+1:2];
    wire wr_ctrl = apb_fin && pwrite && hit_ctrl;
    wire wr_flag = apb_fin && pwrite && hit_flag;

    wire glb_en = flag_q[`IAC_FB_I];
    wire [`IAC_LVL_W-1:0] cpu_priority_floor = flag_q[`IAC_FB_IPL_HI:`IAC_FB_IPL_LO];
    wire idle = st_q == IAC_S_IDLE;

    // Only the synchronised filter levels feed the edge detector.
    logic [`IAC_NEDGE-1:0] edge_rise, edge_fall;
    always_comb
    begin
        for (int e = 0; e < `IAC_NEDGE; e++)
        begin
            filt_d[e] = (sync2_q[e] == sync3_q[e]) ? sync3_q[e] : filt_q[e];
            edge_rise[e] = filt_d[e] && !filt_q[e];
            edge_fall[e] = !filt_d[e] && filt_q[e];
        end
    end

    logic [`IAC_NSRC-1:0] req_set, ok_src;
    always_comb
    begin
        for (int i = 0; i < `IAC_NSRC; i++)
        begin
            if (i < `IAC_FIRST_EDGE)
                req_set[i] = src_req[i];
            else if (ctrl_q[i].edge_polarity)
                req_set[i] = edge_rise[i - `IAC_FIRST_EDGE];
            else
                req_set[i] = edge_fall[i - `IAC_FIRST_EDGE];
            // Level zero can never exceed any floor value.
            ok_src[i] = glb_en && ctrl_q[i].pend
                && ctrl_q[i].lvl > cpu_priority_floor;
        end
    end

    wire [`IAC_IDX_W:0] best = pick_best(ok_src, ctrl_q);
    wire mask_ok = best[`IAC_IDX_W];
    wire [`IAC_IDX_W-1:0] best_idx = best[`IAC_IDX_W-1:0];
    wire sp_high = sp_pend_q && sp_kind_q inside
        {IAC_K_RESET, IAC_K_NMI, IAC_K_DBC, IAC_K_WDT};
    wire any_req = mask_ok || sp_pend_q;
    wire boundary = instr_done
        || (string_op_active && any_req);
    wire start = idle && boundary && any_req;
    wire take_mask = mask_ok && !sp_high;
    wire sp_taken = start && !take_mask;
    wire info_cyc = st_q == IAC_S_INFO;
    wire hw_clr_hit = info_cyc && masked_q;

    always_comb
    begin
        for (int i = 0; i < `IAC_NSRC; i++)
        begin
            ctrl_d[i] = ctrl_q[i];
            if (wr_ctrl && widx == i[`IAC_IDX_W-1:0])
            begin
                ctrl_d[i].lvl = pwdata[`IAC_CB_LVL_HI:0];
                ctrl_d[i].edge_polarity = (i >= `IAC_FIRST_EDGE)
                    && pwdata[`IAC_CB_POL];
            end
            // A new request wins over both kinds of clear.
            ctrl_d[i].pend = (ctrl_q[i].pend
                && !(wr_ctrl && widx == i[`IAC_IDX_W-1:0]
                     && !pwdata[`IAC_CB_PEND])
                && !(hw_clr_hit && src_q == i[`IAC_IDX_W-1:0]))
                || req_set[i];
        end
    end

    // Flag word: software writes, entry sequence updates.
    wire keep_u = !masked_q && kind_q == IAC_K_SWI
        && num_q >= `IAC_SWI_KEEP_U;
    always_comb
    begin
        flag_d = flag_q;
        if (st_q == IAC_S_CLRF)
        begin
            flag_d[`IAC_FB_I] = 1'b0;
            flag_d[`IAC_FB_D] = 1'b0;
            if (!keep_u)
                flag_d[`IAC_FB_U] = 1'b0;
        end
        else if (st_q == IAC_S_DONE)
        begin
            if (masked_q)
                flag_d[`IAC_FB_IPL_HI:`IAC_FB_IPL_LO] = lvl_q;
            else if (kind_q == IAC_K_WDT || kind_q == IAC_K_NMI)
                flag_d[`IAC_FB_IPL_HI:`IAC_FB_IPL_LO] = `IAC_IPL_MAX;
            else if (kind_q == IAC_K_RESET)
                flag_d[`IAC_FB_IPL_HI:`IAC_FB_IPL_LO] = `IAC_IPL_RESET;
        end
        else if (wr_flag)
            flag_d = pwdata[15:0];
    end

    // Entry sequence.
    wire [1:0] plast = sp_odd_q ? 2'h3 : 2'h1;
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            IAC_S_IDLE: if (start) st_d = IAC_S_INFO;
            IAC_S_INFO: st_d = IAC_S_SAVE;
            IAC_S_SAVE: st_d = IAC_S_CLRF;
            IAC_S_CLRF: st_d = IAC_S_PUSH;
            IAC_S_PUSH: if (pidx_q == plast) st_d = IAC_S_WAIT;
            IAC_S_WAIT: if (cnt_q == 5'(len_q - 5'd2)) st_d = IAC_S_DONE;
            IAC_S_DONE: st_d = IAC_S_IDLE;
            default: st_d = IAC_S_IDLE;
        endcase
    end

    wire item_sel = sp_odd_q ? pidx_q[1] : pidx_q[0];
    wire [15:0] item = item_sel ? pc_q[15:0]
        : {pc_q[19:16], tmp_q[15:12], tmp_q[7:0]};
    wire [15:0] push_val = !sp_odd_q ? item
        : (pidx_q[0] ? {8'h00, item[15:8]}
                     : {8'h00, item[7:0]});
    wire [5:0] acc_num = take_mask
        ? 6'(`IAC_NUM_BASE + {3'h0, best_idx}) : sp_num_q;

    wire [31:0] stat_word = {13'h0000, lvl_q, 2'b00, num_q, 6'h00,
        late_q, !idle};
    wire [31:0] rd_word = hit_ctrl
        ? {24'h000000, 3'b000, ctrl_q[widx].edge_polarity, ctrl_q[widx].pend,
           ctrl_q[widx].lvl}
        : hit_flag ? {16'h0000, flag_q}
        : hit_stat ? stat_word : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            filt_q <= '0;
            for (int i = 0; i < `IAC_NSRC; i++)
                ctrl_q[i] <= '0;
            flag_q <= `IAC_FLAG_RESET;
        end
        else if (clk_en)
        begin
            sync1_q <= ext_pin;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q <= filt_d;
            ctrl_q <= ctrl_d;
            flag_q <= flag_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end
        else if (clk_en)
        begin
            pready_q <= apb_acc;
            pslverr_q <= apb_acc && !hit_any;
            prdata_q <= (apb_acc && !pwrite) ? rd_word : '0;
        end
    end

    // Special request latch; a fresh request beats its own acceptance.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sp_pend_q <= 1'b0;
            sp_kind_q <= IAC_K_OTHER;
            sp_num_q <= '0;
        end
        else if (clk_en)
        begin
            sp_pend_q <= special_req || (sp_pend_q && !sp_taken);
            if (special_req)
            begin
                sp_kind_q <= special_kind;
                sp_num_q <= special_num;
            end
        end
    end

    // Time from a waiting request to an instruction end is watched.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_q <= '0;
            late_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (start || !any_req || !idle)
                wait_q <= '0;
            else if (wait_q != 5'h1f)
                wait_q <= 5'(wait_q + 5'd1);
            if (start)
                late_q <= 1'b0;
            else if (wait_q >= `IAC_MAX_INSTR_CYC)
                late_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= IAC_S_IDLE;
            cnt_q <= '0;
            len_q <= `IAC_SEQ_BASE;
            pidx_q <= '0;
            masked_q <= 1'b0;
            sp_odd_q <= 1'b0;
            src_q <= '0;
            lvl_q <= '0;
            kind_q <= IAC_K_OTHER;
            num_q <= '0;
            pc_q <= '0;
            tmp_q <= '0;
        end
        else if (clk_en)
        begin
            st_q <= st_d;
            cnt_q <= start ? 5'd0 : 5'(cnt_q + {4'h0, !idle});
            if (st_q == IAC_S_PUSH)
                pidx_q <= 2'(pidx_q + 2'd1);
            else
                pidx_q <= '0;
            if (start)
            begin
                masked_q <= take_mask;
                src_q <= best_idx;
                lvl_q <= take_mask ? ctrl_q[best_idx].lvl : `IAC_LVL_OFF;
                kind_q <= take_mask ? IAC_K_OTHER : sp_kind_q;
                num_q <= acc_num;
                pc_q <= cpu_pc;
                sp_odd_q <= cpu_sp[0];
                len_q <= seq_len(bus_8bit, vector_odd, cpu_sp[0],
                    sp_kind_q, take_mask);
            end
            if (info_cyc)
                tmp_q <= flag_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            info_q <= '0;
            push_q <= '0;
            done_q <= 1'b0;
            susp_q <= 1'b0;
            busy_q <= 1'b0;
        end
        else if (clk_en)
        begin
            info_q.rd <= st_d == IAC_S_INFO;
            info_q.addr <= `IAC_INFO_ADDR;
            info_q.num <= start ? acc_num : info_q.num;
            info_q.lvl <= start && take_mask
                ? ctrl_q[best_idx].lvl : (start ? `IAC_LVL_OFF : info_q.lvl);
            push_q.stb <= st_q == IAC_S_PUSH;
            push_q.byte_wide <= sp_odd_q;
            push_q.data <= st_q == IAC_S_PUSH ? push_val : '0;
            done_q <= st_q == IAC_S_DONE;
            susp_q <= start && !instr_done;
            busy_q <= st_d != IAC_S_IDLE;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign info = info_q;
    assign push = push_q;
    assign flag_word = flag_q;
    assign seq_busy = busy_q;
    assign seq_done = done_q;
    assign suspend = susp_q;

endmodule

`default_nettype wire

// File: verilog/iac_cfg.svh
// Purpose: Constants for the maskable interrupt acceptance block.
// Assumes: Included by the package and the design module.
// Notes: Offsets are byte addresses on the register bus.
`ifndef IAC_CFG_SVH
`define IAC_CFG_SVH

`define IAC_NSRC 8
`define IAC_IDX_W 3
`define IAC_FIRST_EDGE 6
`define IAC_NEDGE 2
`define IAC_LVL_W 3
`define IAC_LVL_OFF 3'h0
`define IAC_IPL_MAX 3'h7
`define IAC_IPL_RESET 3'h0

`define IAC_CB_LVL_HI 2
`define IAC_CB_PEND 3
`define IAC_CB_POL 4

`define IAC_ADDR_W 12
`define IAC_OFF_CTRL0 12'h000
`define IAC_CTRL_SPAN 12'h020
`define IAC_OFF_FLAG 12'h040
`define IAC_OFF_STAT 12'h044

`define IAC_FLAG_RESET 16'h0000
`define IAC_FB_D 2
`define IAC_FB_I 6
`define IAC_FB_U 7
`define IAC_FB_IPL_LO 12
`define IAC_FB_IPL_HI 14

`define IAC_ST_BUSY 0
`define IAC_ST_LATE 1
`define IAC_ST_NUM_LO 8
`define IAC_ST_NUM_HI 13
`define IAC_ST_LVL_LO 16
`define IAC_ST_LVL_HI 18

`define IAC_INFO_ADDR 20'h00000
`define IAC_NUM_BASE 6'h15
`define IAC_SWI_KEEP_U 6'h20

`define IAC_MAX_INSTR_CYC 5'd30
`define IAC_SEQ_BASE 5'd18
`define IAC_SEQ_BUS8 5'd20
`define IAC_EXTRA_DBC 5'd2
`define IAC_EXTRA_ONE 5'd1
`define IAC_STEP_PUSH 5'd3

`endif

// File: verilog/iac_pkg.sv
// Purpose: Types shared by the interrupt acceptance design and its bench.
// Assumes: iac_cfg.svh supplies the widths.
// Notes: Field layouts of the carriers live here.
`default_nettype none
`include "iac_cfg.svh"

package iac_pkg;

    typedef struct packed {
        logic edge_polarity;
        logic pend;
        logic [`IAC_LVL_W-1:0] lvl;
    } iac_ctrl_t;

    typedef struct packed {
        logic rd;
        logic [19:0] addr;
        logic [5:0] num;
        logic [`IAC_LVL_W-1:0] lvl;
    } iac_info_t;

    typedef struct packed {
        logic stb;
        logic byte_wide;
        logic [15:0] data;
    } iac_push_t;

    typedef enum logic [2:0] {
        IAC_K_RESET = 3'h0,
        IAC_K_NMI = 3'h1,
        IAC_K_DBC = 3'h2,
        IAC_K_WDT = 3'h3,
        IAC_K_SSTEP = 3'h4,
        IAC_K_ADDR = 3'h5,
        IAC_K_SWI = 3'h6,
        IAC_K_OTHER = 3'h7
    } iac_kind_t;

    typedef enum logic [2:0] {
        IAC_S_IDLE = 3'h0,
        IAC_S_INFO = 3'h1,
        IAC_S_SAVE = 3'h3,
        IAC_S_CLRF = 3'h2,
        IAC_S_PUSH = 3'h6,
        IAC_S_WAIT = 3'h7,
        IAC_S_DONE = 3'h5
    } iac_state_t;

endpackage

`default_nettype wire

// File: tb/iac_asserts.sv
// Purpose: Port checks of the interrupt acceptance block.
// Assumes: cpu_pc, cpu_sp and bus_8bit are held during a sequence.
// Notes: Maskable entries carry numbers 0x15 to 0x1c.
`default_nettype none
module iac_asserts
    import iac_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic instr_done,
    input wire logic string_op_active,
    input wire logic [19:0] cpu_pc,
    input wire logic [15:0] cpu_sp,
    input wire logic bus_8bit,
    input wire iac_info_t info,
    input wire iac_push_t push,
    input wire logic [15:0] flag_word,
    input wire logic seq_busy,
    input wire logic seq_done,
    input wire logic suspend
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic msk = info.num >= 6'h15 && info.num < 6'h1d;
    property p_rd_start;
        $rose(seq_busy) |-> info.rd && info.addr == 20'h00000;
    endproperty
    a_rd_start: assert property (p_rd_start)
        else $error("entry began without the info read");
    property p_accept;
        info.rd && msk |-> info.lvl != 3'h0 && $past(flag_word[6])
            && info.lvl > $past(flag_word[14:12]);
    endproperty
    a_accept: assert property (p_accept)
        else $error("maskable source taken against enable or floor");
    property p_clear;
        info.rd |-> ##3 !flag_word[6] && !flag_word[2];
    endproperty
    a_clear: assert property (p_clear)
        else $error("enable or debug flag not cleared");
    property p_push_hi;
        $rose(push.stb) && !push.byte_wide
            |-> push.data[15:12] == cpu_pc[19:16];
    endproperty
    a_push_hi: assert property (p_push_hi)
        else $error("first push lacks upper counter bits");
    property p_push_lo;
        push.stb && !push.byte_wide && $past(push.stb)
            |-> push.data == cpu_pc[15:0];
    endproperty
    a_push_lo: assert property (p_push_lo)
        else $error("second push is not the lower counter");
    property p_byte;
        $rose(push.stb) && !bus_8bit |-> push.byte_wide == cpu_sp[0];
    endproperty
    a_byte: assert property (p_byte)
        else $error("push width does not follow stack parity");
    property p_ipl;
        seq_done && msk |-> flag_word[14:12] == info.lvl;
    endproperty
    a_ipl: assert property (p_ipl)
        else $error("floor not loaded with accepted level");
    property p_susp;
        suspend |-> $past(string_op_active) && !$past(instr_done);
    endproperty
    a_susp: assert property (p_susp)
        else $error("suspend without a string instruction");
    property p_ctrl_rd;
        pready && !pwrite && paddr < 12'h020 |-> prdata[31:8] == 24'h0
            && (paddr >= 12'h018 || !prdata[4]);
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd)
        else $error("unassigned control bits read nonzero");
    c_mask: cover property (info.rd && msk);
    c_susp: cover property (suspend);
    c_bytes: cover property (push.stb && push.byte_wide);
    c_err: cover property (pslverr);
endmodule

bind iac_top iac_asserts u_asserts (
    .pclk(pclk), .presetn(presetn), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_done(instr_done), .string_op_active(string_op_active),
    .cpu_pc(cpu_pc), .cpu_sp(cpu_sp), .bus_8bit(bus_8bit), .info(info),
    .push(push), .flag_word(flag_word), .seq_busy(seq_busy),
    .seq_done(seq_done), .suspend(suspend)
);
`default_nettype wire

// File: tb/iac_cpu_model.sv
// Purpose: CPU core stand-in that paces instruction ends.
// Assumes: The bench supplies settings.
// Notes: Settings load only while idle so a sequence sees fixed values.
`default_nettype none
module iac_cpu_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic seq_busy,
    input wire logic str_mode,
    input wire logic [4:0] per,
    input wire logic [19:0] pc_s,
    input wire logic [15:0] sp_s,
    input wire logic vo_s,
    input wire logic b8_s,
    output logic instr_done,
    output logic string_op_active,
    output logic [19:0] cpu_pc,
    output logic [15:0] cpu_sp,
    output logic vector_odd,
    output logic bus_8bit
);
    logic [4:0] cnt_q;
    wire logic hit = cnt_q >= per;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 5'h00;
            instr_done <= 1'b0;
            string_op_active <= 1'b0;
        end
        else
        begin
            cnt_q <= hit ? 5'h00 : cnt_q + 5'h01;
            instr_done <= hit && !str_mode;
            string_op_active <= str_mode;
        end
    end
    // A real core keeps its counter and stack pointer during entry.
    always_ff @(posedge pclk)
    begin
        if (!seq_busy)
        begin
            cpu_pc <= pc_s;
            cpu_sp <= sp_s;
            vector_odd <= vo_s;
            bus_8bit <= b8_s;
        end
    end
endmodule
`default_nettype wire

// File: tb/maskable_interrupt_acceptance_bench.sv
// Purpose: Self-checking bench for the interrupt acceptance block.
// Assumes: All stimulus changes at rising edges.
// Notes: Drivers queue expectations; a monitor compares them.
`default_nettype none
module maskable_interrupt_acceptance_bench
    import iac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [4:0] len;
        logic [5:0] num;
        logic [2:0] lvl;
        logic ml;
        logic [11:0] fl;
    } iac_exp_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, special_req = 1'b0, str_mode = 1'b0;
    logic vo_s = 1'b0, b8_s = 1'b0, first = 1'b0, clk_en = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [5:0] src_req = 6'h00, special_num = 6'h00, snum;
    logic [1:0] ext_pin = 2'h3;
    iac_kind_t special_kind = IAC_K_OTHER;
    logic [4:0] per = 5'h04;
    logic [19:0] pc_s = 20'h0, cpu_pc;
    logic [15:0] sp_s = 16'h0, cpu_sp, flag_word;
    logic [31:0] prdata;
    logic pready, pslverr, instr_done, string_op_active, vector_odd;
    logic bus_8bit, seq_busy, seq_done, suspend;
    iac_info_t info;
    iac_push_t push;
    int mismatches = 0, compares = 0, cyc = 0, ecyc = 0;
    logic [32:0] q_rd [$];
    iac_exp_t q_ent [$];
    iac_exp_t cur;
    always #50 pclk = ~pclk;
    iac_top uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_req(src_req), .ext_pin(ext_pin),
        .instr_done(instr_done), .string_op_active(string_op_active),
        .cpu_pc(cpu_pc), .cpu_sp(cpu_sp), .vector_odd(vector_odd),
        .bus_8bit(bus_8bit), .special_req(special_req),
        .special_kind(special_kind), .special_num(special_num),
        .info(info), .push(push), .flag_word(flag_word),
        .seq_busy(seq_busy), .seq_done(seq_done), .suspend(suspend));
    iac_cpu_model u_cpu (.pclk(pclk), .presetn(presetn),
        .seq_busy(seq_busy), .str_mode(str_mode), .per(per), .pc_s(pc_s),
        .sp_s(sp_s), .vo_s(vo_s), .b8_s(b8_s), .instr_done(instr_done),
        .string_op_active(string_op_active), .cpu_pc(cpu_pc),
        .cpu_sp(cpu_sp), .vector_odd(vector_odd), .bus_8bit(bus_8bit));
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [32:0] e);
        if (!w)
            q_rd.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        apb(1'b0, a, 32'h0, e);
    endtask
    task automatic pulse(input logic [5:0] m);
        src_req <= m;
        @(posedge pclk);
        src_req <= 6'h00;
        @(posedge pclk);
    endtask
    task automatic wait_done();
        do
            @(posedge pclk);
        while (seq_done !== 1'b1);
        @(posedge pclk);
    endtask
    task automatic rnd();
        pc_s <= 20'($urandom);
        sp_s <= 16'($urandom);
        vo_s <= 1'($urandom);
        b8_s <= 1'($urandom);
        per <= 5'($urandom_range(30, 1));
    endtask
    function automatic logic [4:0] elen(input int k);
        elen = (b8_s ? 5'd20 : 5'd18 + 5'(vo_s) + 5'(sp_s[0]))
            + (k == 2 ? 5'd2 : (k == 4 || k == 5) ? 5'd1 : 5'd0);
    endfunction
    always @(negedge pclk)
    begin
        ecyc = ecyc + 1;
        if (pready === 1'b1 && pwrite === 1'b0)
            chk({pslverr, prdata}, q_rd.pop_front());
        if (info.rd === 1'b1)
        begin
            if (q_ent.size() == 0)
                chk(33'h1, 33'h0);
            else
            begin
                cur = q_ent.pop_front();
                chk(33'(info.num), 33'(cur.num));
                if (cur.ml)
                    chk(33'(info.lvl), 33'(cur.lvl));
                chk(33'(suspend), 33'(str_mode));
                ecyc = 0;
                first = 1'b1;
            end
        end
        if (push.stb === 1'b1 && first)
        begin
            if (!push.byte_wide)
                chk(33'(push.data[11:0]), 33'(cur.fl));
            first = 1'b0;
        end
        if (seq_done === 1'b1)
            chk(33'(ecyc), 33'(cur.len));
        cyc = cyc + 1;
        if (cyc > 40000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial
    begin
        void'($urandom(75));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h040, 33'h0);
        // A request seen while the clock enable is low must leave no trace.
        clk_en <= 1'b0;
        pulse(6'h01);
        clk_en <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            rd(12'(4 * i), 33'h0);
            wr(12'(4 * i), 32'h1f);
            rd(12'(4 * i), i > 5 ? 33'h17 : 33'h07);
        end
        rd(12'h080, 33'h100000000);
        rd(12'h002, 33'h100000000);
        for (int p = 0; p < 8; p++)
        begin
            rnd();
            wr(12'h040, 32'h0);
            for (int i = 0; i < 8; i++)
                wr(12'(4 * i), 32'h0);
            wr(12'h008, 32'(p));
            wr(12'h00c, 32'(p + 1) & 32'h7);
            wr(12'h010, 32'(p + 1) & 32'h7);
            pulse(6'h1c);
            if (p < 7)
                q_ent.push_back('{elen(7), 6'h18, 3'(p + 1), 1'b1,
                    {4'(p), 8'h44}});
            repeat (2) @(posedge pclk);
            wr(12'h040, 32'h44 | 32'(p) << 12);
            if (p < 7)
                wait_done();
            else
                repeat (40) @(posedge pclk);
            rd(12'h008, 33'(8 + p));
            rd(12'h00c, p < 7 ? 33'(p + 1) : 33'h8);
            rd(12'h010, 33'h8 | 33'(p + 1) & 33'h7);
            wr(12'h008, 32'(p));
            rd(12'h008, 33'(p));
        end
        rnd();
        wr(12'h040, 32'h0);
        wr(12'h014, 32'h5);
        pulse(6'h20);
        repeat (40) @(posedge pclk);
        str_mode <= 1'b1;
        q_ent.push_back('{elen(7), 6'h1a, 3'h5, 1'b1, 12'h040});
        wr(12'h040, 32'h40);
        wait_done();
        str_mode <= 1'b0;
        rd(12'h044, 33'h00051a00);
        for (int j = 0; j < 2; j++)
        begin
            wr(12'(24 + 4 * j), 32'h1 | 32'(j) << 4);
            repeat (8) @(posedge pclk);
            wr(12'(24 + 4 * j), 32'h1 | 32'(j) << 4);
            ext_pin[j] <= ~j[0];
            repeat (8) @(posedge pclk);
            rd(12'(24 + 4 * j), 33'h1 | 33'(j) << 4);
            ext_pin[j] <= j[0];
            repeat (8) @(posedge pclk);
            rd(12'(24 + 4 * j), 33'h9 | 33'(j) << 4);
        end
        for (int k = 0; k < 8; k++)
        begin
            rnd();
            wr(12'h040, 32'h30c4);
            snum = k == 6 ? 6'h21 : 6'(48 + k);
            q_ent.push_back('{elen(k), snum, 3'h0, 1'b0, 12'h3c4});
            special_kind <= iac_kind_t'(k);
            special_num <= snum;
            special_req <= 1'b1;
            @(posedge pclk);
            special_req <= 1'b0;
            wait_done();
            chk(33'(flag_word), {18'h0, k == 1 || k == 3 ? 3'h7 : k == 0 ?
                3'h0 : 3'h3, 4'h0, k == 6, 7'h0});
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
